// [pkg/fhp_map.svh]
`ifndef FHP_MAP_SVH
`define FHP_MAP_SVH
// Operation
// - Alternate mode: status bits 2,1 return the last written rate code.
// - Rate code 00=500K, 01=300K, 10=250K, 11=1M bits per second.
// - Legacy mode: status bits 6..0 are left undriven on reads.
// - Status bits 6..3 read as ones whenever driven.
// - Status bit 7 reads 1 while media-changed input is low.
// - Rate code keeps across software reset; hardware reset loads 10.
// - Effective rate comes from the most recent rate or configuration write.
// - First command byte fixes parameter count; execution follows last byte.
// - Command-active flag set by first byte, cleared at end of command.
// - Non-DMA modes interrupt per byte and show the request in status.
// - DMA mode only with setup DMA bit 0 and output control bit 3.
// - FIFO off: request per byte, dropped on acknowledge fall; interrupt after.
// - In DMA cycles address lines are ignored; acknowledge selects the FIFO.
// - Terminal count ends the transfer, recognised only with acknowledge low.
// - Legacy mode FIFO off: one byte at a time, request drops between.
// - Alternate mode FIFO off: threshold 0Fh, request returns when acknowledge rises.
// - FIFO reads: request when count is at least 16 minus threshold.
// - Request drops at empty, returns on trigger or after sector last byte.
// - Burst holds request until empty; otherwise drop per byte, 350 ns gap.
// - Non-burst: acknowledge pulse without read strobe counts as one byte read.
// - Threshold is four bits and counts as 0Fh with FIFO disabled.
// - Burst mode is chosen by the mode command; here the cfg_burst input selects it, and only with cfg_fifo_en set.
`define FHP_OFS_OCTL 3'h2
`define FHP_OFS_MSTAT 3'h4
`define FHP_OFS_DSR 3'h4
`define FHP_OFS_DATA 3'h5
`define FHP_OFS_ISTAT 3'h7
`define FHP_OFS_RCFG 3'h7
`define FHP_RATE_RST 2'h2
`define FHP_OCTL_RST 8'h00
`define FHP_OCTL_DMA_BIT 3
`define FHP_OCTL_NRST_BIT 2
`define FHP_ISTAT_RSV 4'hF
`define FHP_ISTAT_LEGACY_OE 8'h80
`define FHP_THR_FIFO_OFF 4'hF
`define FHP_FIFO_SPAN 5'h10
`define FHP_FIFO_DEPTH 8
`define FHP_CLK_NS 5
`define FHP_GAP_NS 350
`define FHP_GAP_CYC ((`FHP_GAP_NS + `FHP_CLK_NS - 1) / `FHP_CLK_NS)
`define FHP_OP_SPECIFY 5'h03
`define FHP_OP_RECAL 5'h07
`define FHP_OP_SEEK 5'h0F
`define FHP_OP_READ 5'h06
`define FHP_OP_SENSE 5'h08
`endif

// [pkg/fhp_pkg.sv]
package fhp_pkg;
   typedef enum logic [1:0] {ph_cmd, ph_exec, ph_result} fhp_phase_e;
   typedef logic [7:0] fhp_byte_t;
endpackage

// [hdl/fhp_fifo.sv]
module fhp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clr,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [CW-1:0] count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wp_reg, rp_reg;
   logic [CW-1:0] cnt_reg;
   logic push, pop;

   assign in_ready = (cnt_reg != CW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rp_reg];
   assign count = cnt_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else if (clr) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// [hdl/fhp_port.sv]
`include "fhp_map.svh"
module fhp_port #(
   parameter int FIFO_DEPTH = `FHP_FIFO_DEPTH,
   parameter int GAP_CYC = `FHP_GAP_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [2:0] addr,
   input wire logic cs_n,
   input wire logic aen,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] d_in,
   output logic [7:0] d_out,
   output logic [7:0] d_oe,
   input wire logic dack_n,
   input wire logic tc,
   output logic drq,
   output logic irq,
   input wire logic media_changed_n,
   input wire logic alt_mode,
   input wire logic cfg_dma_off,
   input wire logic cfg_fifo_en,
   input wire logic [3:0] cfg_fifo_threshold,
   input wire logic cfg_burst,
   output logic [1:0] rate_code,
   output logic [7:0] cmd_byte,
   output logic cmd_strobe,
   output logic exec_start,
   input wire logic [7:0] disk_data,
   input wire logic disk_valid,
   input wire logic disk_last,
   output logic disk_ready,
   input wire logic exec_done,
   input wire logic [7:0] res_data,
   output logic [2:0] res_index,
   output logic xfer_stop
);
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int GW = $clog2(GAP_CYC + 1);

   // ----------------------------------------
   // Bus strobes
   // ----------------------------------------
   logic rd_n_q, wr_n_q, dack_n_q;
   logic rd_end, wr_end, dack_fall, dack_rise, io_sel, reg_wr, reg_rd;
   logic [7:0] octl_reg;
   logic dma_mode, sw_rst;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         dack_n_q <= 1'b1;
      end else begin
         rd_n_q <= rd_n;
         wr_n_q <= wr_n;
         dack_n_q <= dack_n;
      end
   end

   assign rd_end = rd_n && !rd_n_q;
   assign wr_end = wr_n && !wr_n_q;
   assign dack_fall = !dack_n && dack_n_q;
   assign dack_rise = dack_n && !dack_n_q;
   assign io_sel = !cs_n && !aen;
   assign reg_wr = io_sel && wr_end;
   assign reg_rd = io_sel && rd_end;
   assign dma_mode = !cfg_dma_off && octl_reg[`FHP_OCTL_DMA_BIT];
   assign sw_rst = !octl_reg[`FHP_OCTL_NRST_BIT];

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [1:0] rate_reg;

   // Rate survives software reset; only hardware reset reloads it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rate_reg <= `FHP_RATE_RST;
      end else if (reg_wr && (addr == `FHP_OFS_DSR || addr == `FHP_OFS_RCFG)) begin
         rate_reg <= d_in[1:0];
      end
   end
   assign rate_code = rate_reg;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         octl_reg <= `FHP_OCTL_RST;
      end else if (reg_wr && addr == `FHP_OFS_OCTL) begin
         octl_reg <= d_in;
      end
   end

   // ----------------------------------------
   // Command phase sequencing
   // ----------------------------------------
   fhp_pkg::fhp_phase_e phase_reg;
   logic [4:0] op_reg;
   logic [3:0] left_reg;
   logic [2:0] res_idx_reg;
   logic active_reg, cmd_wr, cmd_last, res_rd, res_last, exec_end;
   logic [4:0] op_cur;

   function automatic logic [3:0] param_cnt(input logic [4:0] op);
      case (op)
         `FHP_OP_SPECIFY: param_cnt = 4'h2;
         `FHP_OP_RECAL: param_cnt = 4'h1;
         `FHP_OP_SEEK: param_cnt = 4'h2;
         `FHP_OP_READ: param_cnt = 4'h8;
         default: param_cnt = 4'h0;
      endcase
   endfunction

   function automatic logic [2:0] res_cnt(input logic [4:0] op);
      case (op)
         `FHP_OP_SPECIFY: res_cnt = 3'h0;
         `FHP_OP_RECAL: res_cnt = 3'h0;
         `FHP_OP_SEEK: res_cnt = 3'h0;
         `FHP_OP_READ: res_cnt = 3'h7;
         `FHP_OP_SENSE: res_cnt = 3'h2;
         default: res_cnt = 3'h1;
      endcase
   endfunction

   // Writes outside the command phase are dropped
   assign cmd_wr = reg_wr && addr == `FHP_OFS_DATA && phase_reg == fhp_pkg::ph_cmd;
   assign op_cur = active_reg ? op_reg : d_in[4:0];
   assign cmd_last = active_reg ? (left_reg == 4'h1) : (param_cnt(d_in[4:0]) == 4'h0);
   assign res_rd = reg_rd && addr == `FHP_OFS_DATA && phase_reg == fhp_pkg::ph_result;
   assign res_last = res_idx_reg == res_cnt(op_reg) - 3'h1;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase_reg <= fhp_pkg::ph_cmd;
      end else if (sw_rst) begin
         phase_reg <= fhp_pkg::ph_cmd;
      end else begin
         case (phase_reg)
            fhp_pkg::ph_cmd: begin
               if (cmd_wr && cmd_last) begin
                  phase_reg <= fhp_pkg::ph_exec;
               end
            end
            fhp_pkg::ph_exec: begin
               if (exec_end) begin
                  phase_reg <= (res_cnt(op_reg) != 3'h0) ? fhp_pkg::ph_result
                                                          : fhp_pkg::ph_cmd;
               end
            end
            fhp_pkg::ph_result: begin
               if (res_rd && res_last) begin
                  phase_reg <= fhp_pkg::ph_cmd;
               end
            end
            default: phase_reg <= fhp_pkg::ph_cmd;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         op_reg <= 5'h00;
         left_reg <= 4'h0;
      end else if (cmd_wr) begin
         if (!active_reg) begin
            op_reg <= d_in[4:0];
            left_reg <= param_cnt(d_in[4:0]);
         end else begin
            left_reg <= left_reg - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         active_reg <= 1'b0;
      end else if (sw_rst) begin
         active_reg <= 1'b0;
      end else if (cmd_wr) begin
         active_reg <= !(cmd_last && res_cnt(op_cur) == 3'h0);
      end else if (res_rd && res_last) begin
         active_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         res_idx_reg <= 3'h0;
      end else if (phase_reg != fhp_pkg::ph_result) begin
         res_idx_reg <= 3'h0;
      end else if (res_rd) begin
         res_idx_reg <= res_idx_reg + 3'h1;
      end
   end
   assign res_index = res_idx_reg;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cmd_byte <= 8'h00;
         cmd_strobe <= 1'b0;
         exec_start <= 1'b0;
      end else begin
         cmd_strobe <= cmd_wr;
         exec_start <= cmd_wr && cmd_last;
         if (cmd_wr) begin
            cmd_byte <= d_in;
         end
      end
   end

   // ----------------------------------------
   // Execution data path
   // ----------------------------------------
   logic [7:0] f_data;
   logic f_valid, f_in_ready, f_pop, pop_pio, pop_dma, in_exec;
   logic [CW-1:0] f_count;
   logic tc_seen_reg, done_reg, last_pend_reg, rd_in_dack_reg;

   assign in_exec = phase_reg == fhp_pkg::ph_exec;
   assign xfer_stop = tc_seen_reg;
   assign disk_ready = f_in_ready && in_exec && !tc_seen_reg;
   assign pop_pio = reg_rd && addr == `FHP_OFS_DATA && in_exec && !dma_mode && f_valid;
   // A bare acknowledge pulse counts as one byte taken
   assign pop_dma = dma_mode && in_exec && f_valid
                 && ((rd_end && !dack_n) || (dack_rise && !rd_in_dack_reg));
   assign f_pop = pop_pio || pop_dma;
   assign exec_end = in_exec && (done_reg || tc_seen_reg) && !f_valid;

   fhp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .clr(sw_rst || !in_exec),
      .in_data(disk_data),
      .in_valid(disk_valid && disk_ready),
      .in_ready(f_in_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .count(f_count)
   );

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_in_dack_reg <= 1'b0;
      end else if (dack_n) begin
         rd_in_dack_reg <= 1'b0;
      end else if (rd_end) begin
         rd_in_dack_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tc_seen_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (!in_exec) begin
         tc_seen_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         if (tc && !dack_n) begin
            tc_seen_reg <= 1'b1;
         end
         if (exec_done) begin
            done_reg <= 1'b1;
         end
      end
   end

   // Sector tail forces a request below threshold
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         last_pend_reg <= 1'b0;
      end else if (disk_valid && disk_ready && disk_last) begin
         last_pend_reg <= 1'b1;
      end else if (!f_valid || !in_exec) begin
         last_pend_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Transfer request
   // ----------------------------------------
   logic [3:0] eff_thr;
   logic [4:0] trig_lvl;
   logic trigger, burst_mode, req_reg, run_reg, drop, arm;
   logic [GW-1:0] gap_reg;

   // Disabled FIFO runs at threshold 0Fh: one byte is enough to request
   assign eff_thr = cfg_fifo_en ? cfg_fifo_threshold : `FHP_THR_FIFO_OFF;
   assign trig_lvl = `FHP_FIFO_SPAN - {1'b0, eff_thr};
   assign trigger = (5'(f_count) >= trig_lvl) || last_pend_reg || !f_in_ready;
   assign burst_mode = cfg_fifo_en && cfg_burst;
   assign drop = burst_mode ? (!f_valid || (f_pop && f_count == CW'(1)))
                            : (dma_mode ? dack_fall : pop_pio);
   assign arm = (trigger || run_reg) && f_valid && gap_reg == '0 && dack_n;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         run_reg <= 1'b0;
      end else if (!in_exec || !f_valid) begin
         run_reg <= 1'b0;
      end else if (trigger) begin
         run_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         gap_reg <= '0;
      end else if (f_pop && cfg_fifo_en && !cfg_burst) begin
         gap_reg <= GW'(GAP_CYC);
      end else if (gap_reg != '0) begin
         gap_reg <= gap_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         req_reg <= 1'b0;
      end else if (!in_exec || tc_seen_reg) begin
         req_reg <= 1'b0;
      end else if (req_reg) begin
         req_reg <= !drop;
      end else begin
         req_reg <= arm && !f_pop;
      end
   end

   // ----------------------------------------
   // Interrupt and status
   // ----------------------------------------
   logic res_irq_reg;
   logic [7:0] mstat, istat, rd_mux;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         res_irq_reg <= 1'b0;
      end else if (exec_end && res_cnt(op_reg) != 3'h0 && !sw_rst) begin
         res_irq_reg <= 1'b1;
      end else if (res_rd || sw_rst) begin
         res_irq_reg <= 1'b0;
      end
   end

   assign drq = req_reg && dma_mode;
   assign irq = (req_reg && !dma_mode) || res_irq_reg;

   always_comb begin
      mstat = 8'h00;
      mstat[7] = phase_reg == fhp_pkg::ph_cmd || phase_reg == fhp_pkg::ph_result
               || (in_exec && req_reg && !dma_mode);
      mstat[6] = phase_reg == fhp_pkg::ph_result || (in_exec && !dma_mode);
      mstat[5] = in_exec && !dma_mode;
      mstat[4] = active_reg;
   end

   // Bit 0 reads high for the two low rates
   assign istat = {!media_changed_n, `FHP_ISTAT_RSV, rate_reg,
                   rate_reg[0] ^ rate_reg[1]};

   always_comb begin
      case (addr)
         `FHP_OFS_MSTAT: rd_mux = mstat;
         `FHP_OFS_DATA: rd_mux = in_exec ? f_data : res_data;
         `FHP_OFS_ISTAT: rd_mux = istat;
         default: rd_mux = 8'h00;
      endcase
   end

   // Legacy mode leaves the low status bits to the disk status register
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         d_out <= 8'h00;
         d_oe <= 8'h00;
      end else if (!dack_n && !rd_n && dma_mode) begin
         d_out <= f_data;
         d_oe <= 8'hFF;
      end else if (io_sel && !rd_n && addr == `FHP_OFS_ISTAT) begin
         d_out <= rd_mux;
         d_oe <= alt_mode ? 8'hFF : `FHP_ISTAT_LEGACY_OE;
      end else if (io_sel && !rd_n && (addr == `FHP_OFS_MSTAT || addr == `FHP_OFS_DATA)) begin
         d_out <= rd_mux;
         d_oe <= 8'hFF;
      end else begin
         d_oe <= 8'h00;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_rate_load;
      reg_wr && addr == `FHP_OFS_RCFG |=> rate_code == $past(d_in[1:0]);
   endproperty
   a_rate_load: assert property (p_rate_load) else $error("rate not loaded");

   property p_rate_hold;
      !(reg_wr && (addr == `FHP_OFS_DSR || addr == `FHP_OFS_RCFG)) |=> $stable(rate_code);
   endproperty
   a_rate_hold: assert property (p_rate_hold) else $error("rate changed alone");

   property p_stat_alt;
      io_sel && !rd_n && addr == `FHP_OFS_ISTAT && alt_mode && dack_n
      |=> d_out[6:1] == {4'hF, rate_code} && d_out[7] == !$past(media_changed_n);
   endproperty
   a_stat_alt: assert property (p_stat_alt) else $error("status read wrong");

   property p_stat_legacy;
      io_sel && !rd_n && addr == `FHP_OFS_ISTAT && !alt_mode && (dack_n || !dma_mode)
      |=> d_oe == 8'h80;
   endproperty
   a_stat_legacy: assert property (p_stat_legacy) else $error("low bits driven");

   property p_busy;
      phase_reg == fhp_pkg::ph_result |-> mstat[4] && mstat[7] && mstat[6];
   endproperty
   a_busy: assert property (p_busy) else $error("result status wrong");

   property p_exec_enter;
      cmd_wr && cmd_last && !sw_rst |=> phase_reg == fhp_pkg::ph_exec && exec_start
                                        ##1 exec_start == 1'b0;
   endproperty
   a_exec_enter: assert property (p_exec_enter) else $error("no execution");

   property p_dma_gate;
      drq |-> !cfg_dma_off && octl_reg[`FHP_OCTL_DMA_BIT] && in_exec;
   endproperty
   a_dma_gate: assert property (p_dma_gate) else $error("request outside DMA");

   property p_dack_drop;
      drq && dack_fall && !burst_mode |=> !drq;
   endproperty
   a_dack_drop: assert property (p_dack_drop) else $error("request held");

   property p_tc_gate;
      $rose(tc_seen_reg) |-> $past(tc) && !$past(dack_n);
   endproperty
   a_tc_gate: assert property (p_tc_gate) else $error("stray count");

   property p_gap;
      f_pop && cfg_fifo_en && !cfg_burst && in_exec |=> (!req_reg)[*8];
   endproperty
   a_gap: assert property (p_gap) else $error("gap too short");

   c_burst: cover property (drq && burst_mode ##[1:40] !f_valid);
   c_tc: cover property ($rose(tc_seen_reg));
   c_result: cover property (phase_reg == fhp_pkg::ph_result && res_rd);
endmodule

// [test/fhp_dma_model.sv]
// -----------------------------------------
// System DMA controller seen from the port
// -----------------------------------------
module fhp_dma_model (
   input wire logic clk_sys,
   input wire logic drq,
   input wire logic [7:0] d_out,
   input wire logic use_rd,
   input wire logic tc_next,
   input wire logic [1:0] lag,
   output logic dack_n,
   output logic rd_n,
   output logic tc,
   output logic got,
   output logic [7:0] got_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      dack_n = 1'b1;
      rd_n = 1'b1;
      tc = 1'b0;
      got = 1'b0;
      got_data = 8'h00;
      forever begin
         @(negedge clk_sys);
         got = 1'b0;
         if (drq === 1'b1) begin
            // Random lag stands for a busy channel answering slowly
            repeat (lag) @(negedge clk_sys);
            dack_n = 1'b0;
            tc = tc_next;
            rd_n = !use_rd;
            repeat (3) @(negedge clk_sys);
            got_data = d_out;
            got = use_rd;
            rd_n = 1'b1;
            repeat (2) @(negedge clk_sys);
            dack_n = 1'b1;
            tc = 1'b0;
            repeat (2) @(negedge clk_sys);
         end
      end
   end
endmodule

// [test/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, drq, irq, dack_n, tc, dma_rd_n, exec_start, disk_ready, xfer_stop, got;
   logic [7:0] d_out, d_oe, got_data, disk_data = 8'h00, d_in = 8'h00;
   logic [1:0] rate_code, lag = 2'h0;
   logic [2:0] addr = 3'h0;
   logic [3:0] cfg_fifo_threshold = 4'h0;
   logic reset = 1'b1, cs_n = 1'b1, aen = 1'b0, wr_n = 1'b1, h_rd_n = 1'b1;
   logic media_changed_n = 1'b0, alt_mode = 1'b1, cfg_dma_off = 1'b1, cfg_fifo_en = 1'b0;
   logic cfg_burst = 1'b0, disk_valid = 1'b0, disk_last = 1'b0, exec_done = 1'b0;
   logic use_rd = 1'b1, tc_next = 1'b0;
   logic [31:0] hq[$], e, seed = 32'h34;
   logic [7:0] dq[$];
   int num_errors = 0, compares = 0, n_exec = 0, n_stop = 0, i;

   fhp_port #(.GAP_CYC(8)) dut_u (.clk_sys(clk_sys), .reset(reset), .addr(addr),
      .cs_n(cs_n), .aen(aen), .rd_n(h_rd_n & dma_rd_n), .wr_n(wr_n), .d_in(d_in),
      .d_out(d_out), .d_oe(d_oe), .dack_n(dack_n), .tc(tc), .drq(drq), .irq(irq),
      .media_changed_n(media_changed_n), .alt_mode(alt_mode), .cfg_dma_off(cfg_dma_off),
      .cfg_fifo_en(cfg_fifo_en), .cfg_fifo_threshold(cfg_fifo_threshold), .cfg_burst(cfg_burst),
      .rate_code(rate_code), .cmd_byte(), .cmd_strobe(), .exec_start(exec_start),
      .disk_data(disk_data), .disk_valid(disk_valid), .disk_last(disk_last),
      .disk_ready(disk_ready), .exec_done(exec_done), .res_data(8'h5A), .res_index(),
      .xfer_stop(xfer_stop));
   fhp_dma_model dma_u (.clk_sys(clk_sys), .drq(drq), .d_out(d_out), .use_rd(use_rd),
      .tc_next(tc_next), .lag(lag), .dack_n(dack_n), .rd_n(dma_rd_n), .tc(tc), .got(got),
      .got_data(got_data));

   // -----------------------------------------
   // Checking
   // -----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 300) begin
         num_errors++;
         end_sim();
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Undriven read bits are masked by the enables so that floating data always compares as zero
   always @(posedge h_rd_n) begin
      if (hq.size() > 0) begin
         e = hq.pop_front();
         check({d_oe, d_out & d_oe} & e[31:16], e[15:0]);
      end
   end
   always @(posedge got) begin
      if (dq.size() > 0) begin
         check({8'h00, got_data}, {8'h00, dq.pop_front()});
      end else begin
         check({8'h00, got_data}, 16'hFFFF);
      end
   end
   always @(posedge clk_sys) begin
      if (exec_start === 1'b1) n_exec++;
      if (xfer_stop === 1'b1) n_stop++;
   end

   // -----------------------------------------
   // Drivers
   // -----------------------------------------
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                      input logic [15:0] m, input logic [15:0] x);
      @(negedge clk_sys);
      addr = a;
      d_in = d;
      cs_n = 1'b0;
      wr_n = !w;
      h_rd_n = w;
      if (!w) hq.push_back({m, x});
      repeat (3) @(negedge clk_sys);
      wr_n = 1'b1;
      h_rd_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      cs_n = 1'b1;
   endtask
   task automatic done();
      @(negedge clk_sys);
      exec_done = 1'b1;
      @(negedge clk_sys);
      exec_done = 1'b0;
   endtask
   task automatic push(input logic last);
      int n;
      seed = xs(seed);
      @(negedge clk_sys);
      disk_data = seed[7:0];
      disk_valid = 1'b1;
      disk_last = last;
      lag = seed[9:8];
      if (use_rd) dq.push_back(seed[7:0]);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (disk_ready !== 1'b1 && n < 300);
      tmo(n);
      @(negedge clk_sys);
      disk_valid = 1'b0;
      disk_last = 1'b0;
   endtask
   task automatic wait_pop();
      int n;
      for (n = 0; n < 300 && dack_n !== 1'b0; n++) @(negedge clk_sys);
      tmo(n);
      repeat (2) @(negedge clk_sys);
      check(16'(drq), 16'h0000);
      for (n = 0; n < 300 && dack_n !== 1'b1; n++) @(negedge clk_sys);
      tmo(n);
   endtask

   // -----------------------------------------
   // Sequence
   // -----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = !clk_sys;
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      check(16'(rate_code), 16'h0002);
      bus(1, 3'h2, 8'h04, 0, 0);
      for (i = 0; i < 4; i++) begin
         bus(1, 3'h7, i[7:0], 0, 0);
         check(16'(rate_code), 16'(i[1:0]));
         bus(0, 3'h7, 0, 16'hFFFF, {8'hFF, 5'h1F, i[1:0], i[0] ^ i[1]});
      end
      bus(1, 3'h4, 8'h01, 0, 0);
      check(16'(rate_code), 16'h0001);
      bus(1, 3'h2, 8'h00, 0, 0);
      bus(1, 3'h2, 8'h04, 0, 0);
      check(16'(rate_code), 16'h0001);
      alt_mode = 1'b0;
      media_changed_n = 1'b1;
      bus(0, 3'h7, 0, 16'hFFFF, 16'h8000);
      bus(0, 3'h1, 0, 16'hFFFF, 16'h0000);
      bus(1, 3'h5, 8'h03, 0, 0);
      bus(0, 3'h4, 0, 16'h00D0, 16'h0090);
      bus(1, 3'h5, 8'h11, 0, 0);
      bus(1, 3'h5, 8'h22, 0, 0);
      check(16'(n_exec), 16'h0001);
      bus(0, 3'h4, 0, 16'h0010, 16'h0000);
      done();
      bus(1, 3'h5, 8'h08, 0, 0);
      check(16'(n_exec), 16'h0002);
      done();
      bus(0, 3'h4, 0, 16'h00D0, 16'h00D0);
      check(16'(irq), 16'h0001);
      bus(0, 3'h5, 0, 16'hFFFF, 16'hFF5A);
      check(16'(irq), 16'h0000);
      bus(0, 3'h5, 0, 16'hFFFF, 16'hFF5A);
      bus(0, 3'h4, 0, 16'h0010, 16'h0000);
      // DMA gating and alternate mode are set before the command starts
      bus(1, 3'h2, 8'h0C, 0, 0);
      cfg_dma_off = 1'b0;
      alt_mode = 1'b1;
      for (i = 0; i < 9; i++) bus(1, 3'h5, (i == 0) ? 8'h06 : 8'h00, 0, 0);
      aen = 1'b1;
      cfg_fifo_en = 1'b1;
      cfg_fifo_threshold = 4'hE;
      cfg_burst = 1'b1;
      push(1'b0);
      repeat (20) @(negedge clk_sys);
      check(16'(drq), 16'h0000);
      push(1'b0);
      for (i = 0; i < 300 && dq.size() > 0; i++) @(negedge clk_sys);
      tmo(i);
      cfg_fifo_threshold = 4'hF;
      cfg_burst = 1'b0;
      // Two bytes through the enabled FIFO without burst, then two with it off
      for (i = 0; i < 4; i++) begin
         cfg_fifo_en = (i < 2);
         use_rd = (i != 2);
         tc_next = (i == 3);
         push(i == 3);
         wait_pop();
         check(16'(n_stop > 0), 16'(i == 3));
      end
      for (i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clk_sys);
      tmo(i);
      aen = 1'b0;
      for (i = 0; i < 7; i++) bus(0, 3'h5, 0, 16'hFFFF, 16'hFF5A);
      bus(0, 3'h4, 0, 16'h0010, 16'h0000);
      // Programmed transfer: interrupt and status request per byte
      cfg_dma_off = 1'b1;
      use_rd = 1'b0;
      for (i = 0; i < 9; i++) bus(1, 3'h5, (i == 0) ? 8'h06 : 8'h00, 0, 0);
      push(1'b1);
      repeat (2) @(negedge clk_sys);
      check(16'(irq), 16'h0001);
      bus(0, 3'h4, 0, 16'h00F0, 16'h00F0);
      bus(0, 3'h5, 0, 16'hFFFF, {8'hFF, seed[7:0]});
      check(16'(irq), 16'h0000);
      done();
      for (i = 0; i < 7; i++) bus(0, 3'h5, 0, 16'hFFFF, 16'hFF5A);
      bus(0, 3'h4, 0, 16'h0010, 16'h0000);
      end_sim();
   end
endmodule
